// ---- fsc_pkg.sv ----
/*
  Constants for the fast system call register logic: register addresses,
  field positions and selector offsets.
  Assumes a core that presents decoded instructions and register accesses.
*/
// Behaviour
// - Entry loads code selector; stack selector plus 8
// - Return to 32-bit copies return selector
// - Return to 64-bit: code selector plus 16
// - Return stack selector always return field plus 8
// - Low 32 bits: entry target outside long mode
// - Long mode target from long or compat pointer
// - Non-canonical pointer write raises protection fault
// - Long mode entry clears flag bits selected by mask
// - Target privilege not checked; fixed 0 and 3
// - Fixed selector and hidden segment state loaded
// - Legacy entry/exit in long mode: undefined opcode
// - Legacy entry uses registers 174h, 175h, 176h
// - Long mode exchange swaps saved kernel base with aux base
// - Exchange needs no register or memory operands
// - Target config fully readable and writable
package fsc_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [31:0] ADDR_LEG_CS   = 32'h0000_0174;
  localparam logic [31:0] ADDR_LEG_SP   = 32'h0000_0175;
  localparam logic [31:0] ADDR_LEG_IP   = 32'h0000_0176;
  localparam logic [31:0] ADDR_KBASE    = 32'hC000_0102;
  localparam logic [31:0] ADDR_TARGET   = 32'hC000_0081;
  localparam logic [31:0] ADDR_LPTR     = 32'hC000_0082;
  localparam logic [31:0] ADDR_CPTR     = 32'hC000_0083;
  localparam logic [31:0] ADDR_FMASK    = 32'hC000_0084;
  // ==========================================================
  // Field positions, selector offsets, reset value, privilege levels and address width
  localparam int          RET_SEL_LSB   = 48;
  localparam int          ENT_SEL_LSB   = 32;
  localparam logic [15:0] SEL_STEP_SS   = 16'h0008;
  localparam logic [15:0] SEL_STEP_CS64 = 16'h0010;
  localparam logic [63:0] RESET_VAL     = 64'h0000_0000_0000_0000;
  localparam logic [1:0]  PRIV_KERNEL   = 2'h0;
  localparam logic [1:0]  PRIV_USER     = 2'h3;
  localparam int          VA_BITS       = 48;
  // Operation codes presented by the core
  typedef enum logic [2:0] {
    FSC_OP_NONE    = 3'h0,
    FSC_OP_ENTRY   = 3'h1,
    FSC_OP_RETURN  = 3'h3,
    FSC_OP_LENTRY  = 3'h2,
    FSC_OP_LEXIT   = 3'h6,
    FSC_OP_XCHG    = 3'h7
  } fsc_op_t;
endpackage : fsc_pkg

// ---- fsc_core.sv ----
/*
  Fast system call register logic: model registers, selector and target
  generation, flag masking, kernel base exchange and fault reporting.
  Assumes the core issues at most one operation or register access per cycle.
*/
`timescale 1ns/1ns
module fsc_core
(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // Model register access
  input  wire logic              msr_wr_i,
  input  wire logic              msr_rd_i,
  input  wire logic [31:0]       msr_addr_i,
  input  wire logic [63:0]       msr_wdata_i,
  output logic      [63:0]       msr_rdata_o,
  output logic                   msr_ack_o,
  output logic                   protection_fault_o,
  // Operation request
  input  wire logic              op_valid_i,
  input  wire fsc_pkg::fsc_op_t  op_i,
  input  wire logic              long_mode_i,
  input  wire logic              caller_64_i,
  input  wire logic              ret_to_64_i,
  input  wire logic [63:0]       flag_word_i,
  input  wire logic [63:0]       aux_base_i,
  // Operation result
  output logic                   res_valid_o,
  output logic                   undefined_opcode_fault_o,
  output logic      [15:0]       code_sel_o,
  output logic      [15:0]       stack_sel_o,
  output logic      [1:0]        current_privilege_level_o,
  output logic                   flat_seg_load_o,
  output logic      [63:0]       target_ip_o,
  output logic      [63:0]       stack_ptr_o,
  output logic      [63:0]       flag_word_o,
  output logic                   aux_base_we_o,
  output logic      [63:0]       aux_base_o
);
  // ==========================================================
  // Registers
  logic [63:0] leg_cs_q, leg_sp_q, leg_ip_q, kbase_q;
  logic [63:0] target_q, lptr_q, cptr_q, fmask_q;
  logic        canon_ok;
  logic        ptr_wr;
  logic        xchg;
  logic [15:0] ent_sel, ret_sel;

  // Address is canonical when bits 63:47 all match
  assign canon_ok = (&msr_wdata_i[63:fsc_pkg::VA_BITS-1])
                  | ~(|msr_wdata_i[63:fsc_pkg::VA_BITS-1]);
  assign ptr_wr   = msr_wr_i && (msr_addr_i == fsc_pkg::ADDR_LPTR
                                 || msr_addr_i == fsc_pkg::ADDR_CPTR);
  assign xchg     = op_valid_i && op_i == fsc_pkg::FSC_OP_XCHG && long_mode_i;
  assign ent_sel  = target_q[fsc_pkg::ENT_SEL_LSB +: 16];
  assign ret_sel  = target_q[fsc_pkg::RET_SEL_LSB +: 16];

  // Register writes; pointer writes that are non-canonical are dropped
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      leg_cs_q <= fsc_pkg::RESET_VAL;
      leg_sp_q <= fsc_pkg::RESET_VAL;
      leg_ip_q <= fsc_pkg::RESET_VAL;
      target_q <= fsc_pkg::RESET_VAL;
      lptr_q   <= fsc_pkg::RESET_VAL;
      cptr_q   <= fsc_pkg::RESET_VAL;
      fmask_q  <= fsc_pkg::RESET_VAL;
    end
    else if (msr_wr_i)
    begin
      case (msr_addr_i)
        fsc_pkg::ADDR_LEG_CS: leg_cs_q <= msr_wdata_i;
        fsc_pkg::ADDR_LEG_SP: leg_sp_q <= msr_wdata_i;
        fsc_pkg::ADDR_LEG_IP: leg_ip_q <= msr_wdata_i;
        fsc_pkg::ADDR_TARGET: target_q <= msr_wdata_i;
        fsc_pkg::ADDR_LPTR:   if (canon_ok) lptr_q <= msr_wdata_i;
        fsc_pkg::ADDR_CPTR:   if (canon_ok) cptr_q <= msr_wdata_i;
        fsc_pkg::ADDR_FMASK:  fmask_q  <= msr_wdata_i;
        default: ;
      endcase
    end
  end

  // Saved kernel base: exchange takes the aux base, software write otherwise
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      kbase_q <= fsc_pkg::RESET_VAL;
    else if (xchg)
      kbase_q <= aux_base_i;
    else if (msr_wr_i && msr_addr_i == fsc_pkg::ADDR_KBASE)
      kbase_q <= msr_wdata_i;
  end

  // Register read and access answer
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      msr_rdata_o        <= fsc_pkg::RESET_VAL;
      msr_ack_o          <= 1'b0;
      protection_fault_o <= 1'b0;
    end
    else
    begin
      msr_ack_o          <= msr_rd_i | msr_wr_i;
      protection_fault_o <= ptr_wr && !canon_ok;
      if (msr_rd_i)
      begin
        case (msr_addr_i)
          fsc_pkg::ADDR_LEG_CS: msr_rdata_o <= leg_cs_q;
          fsc_pkg::ADDR_LEG_SP: msr_rdata_o <= leg_sp_q;
          fsc_pkg::ADDR_LEG_IP: msr_rdata_o <= leg_ip_q;
          fsc_pkg::ADDR_KBASE:  msr_rdata_o <= kbase_q;
          fsc_pkg::ADDR_TARGET: msr_rdata_o <= target_q;
          fsc_pkg::ADDR_LPTR:   msr_rdata_o <= lptr_q;
          fsc_pkg::ADDR_CPTR:   msr_rdata_o <= cptr_q;
          fsc_pkg::ADDR_FMASK:  msr_rdata_o <= fmask_q;
          default:              msr_rdata_o <= fsc_pkg::RESET_VAL;
        endcase
      end
    end
  end

  // Operation results, one cycle after the request
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      res_valid_o               <= 1'b0;
      undefined_opcode_fault_o  <= 1'b0;
      code_sel_o                <= 16'h0000;
      stack_sel_o               <= 16'h0000;
      current_privilege_level_o <= fsc_pkg::PRIV_KERNEL;
      flat_seg_load_o           <= 1'b0;
      target_ip_o               <= fsc_pkg::RESET_VAL;
      stack_ptr_o               <= fsc_pkg::RESET_VAL;
      flag_word_o               <= fsc_pkg::RESET_VAL;
      aux_base_we_o             <= 1'b0;
      aux_base_o                <= fsc_pkg::RESET_VAL;
    end
    else
    begin
      res_valid_o              <= op_valid_i && op_i != fsc_pkg::FSC_OP_NONE;
      undefined_opcode_fault_o <= 1'b0;
      flat_seg_load_o          <= 1'b0;
      aux_base_we_o            <= 1'b0;
      if (op_valid_i)
      begin
        case (op_i)
          fsc_pkg::FSC_OP_ENTRY:
          begin
            code_sel_o                <= ent_sel;
            stack_sel_o               <= 16'(ent_sel + fsc_pkg::SEL_STEP_SS);
            current_privilege_level_o <= fsc_pkg::PRIV_KERNEL;
            flat_seg_load_o           <= 1'b1;
            if (!long_mode_i)
            begin
              target_ip_o <= {32'h0000_0000, target_q[31:0]};
              flag_word_o <= flag_word_i;
            end
            else
            begin
              target_ip_o <= caller_64_i ? lptr_q : cptr_q;
              flag_word_o <= flag_word_i & ~fmask_q;
            end
          end
          fsc_pkg::FSC_OP_RETURN:
          begin
            code_sel_o                <= ret_to_64_i
                                         ? 16'(ret_sel + fsc_pkg::SEL_STEP_CS64)
                                         : ret_sel;
            stack_sel_o               <= 16'(ret_sel + fsc_pkg::SEL_STEP_SS);
            current_privilege_level_o <= fsc_pkg::PRIV_USER;
            flat_seg_load_o           <= 1'b1;
          end
          fsc_pkg::FSC_OP_LENTRY:
          begin
            if (long_mode_i)
              undefined_opcode_fault_o <= 1'b1;
            else
            begin
              code_sel_o                <= leg_cs_q[15:0];
              stack_sel_o               <= 16'(leg_cs_q[15:0] + fsc_pkg::SEL_STEP_SS);
              target_ip_o               <= leg_ip_q;
              stack_ptr_o               <= leg_sp_q;
              current_privilege_level_o <= fsc_pkg::PRIV_KERNEL;
              flat_seg_load_o           <= 1'b1;
            end
          end
          fsc_pkg::FSC_OP_LEXIT:
          begin
            if (long_mode_i)
              undefined_opcode_fault_o <= 1'b1;
          end
          fsc_pkg::FSC_OP_XCHG:
          begin
            if (long_mode_i)
            begin
              aux_base_o    <= kbase_q;
              aux_base_we_o <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule : fsc_core

// ---- fsc_core_monitor.sv ----
/*
  Port checker for the fast system call register logic.
  Assumes one core clock and the active-low reset of fsc_core.
*/
`timescale 1ns/1ns
module fsc_core_mon
(
  // Clock, reset and requests
  input wire logic             sys_clk_i,
  input wire logic             nrst_i,
  input wire logic             msr_wr_i,
  input wire logic             msr_rd_i,
  input wire logic             op_valid_i,
  input wire fsc_pkg::fsc_op_t op_i,
  input wire logic             long_mode_i,
  input wire logic             ret_to_64_i,
  input wire logic [63:0]      flag_word_i,
  // Results
  input wire logic             msr_ack_o,
  input wire logic             protection_fault_o,
  input wire logic             res_valid_o,
  input wire logic             undefined_opcode_fault_o,
  input wire logic [15:0]      code_sel_o,
  input wire logic [15:0]      stack_sel_o,
  input wire logic [1:0]       current_privilege_level_o,
  input wire logic             flat_seg_load_o,
  input wire logic [63:0]      flag_word_o,
  input wire logic             aux_base_we_o
);
  // ==========================================================
  // Decoded requests
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  wire ent_w = op_valid_i && op_i == fsc_pkg::FSC_OP_ENTRY;
  wire ret_w = op_valid_i && op_i == fsc_pkg::FSC_OP_RETURN;
  wire leg_w = op_valid_i && long_mode_i
             && (op_i == fsc_pkg::FSC_OP_LENTRY || op_i == fsc_pkg::FSC_OP_LEXIT);
  // ==========================================================
  // Assertions
  acc_ack_a: assert property ((msr_wr_i || msr_rd_i) |=> msr_ack_o) else $error("no ack");
  op_done_a: assert property (op_valid_i && op_i != fsc_pkg::FSC_OP_NONE |=> res_valid_o)
    else $error("no result");
  ent_sel_a: assert property (ent_w |=> stack_sel_o == code_sel_o + 16'h8)
    else $error("entry stack selector");
  ret32_sel_a: assert property (ret_w && !ret_to_64_i |=> stack_sel_o == code_sel_o + 16'h8)
    else $error("return 32 selectors");
  ret64_sel_a: assert property (ret_w && ret_to_64_i |=> code_sel_o == stack_sel_o + 16'h8)
    else $error("return 64 selectors");
  ent_priv_a: assert property (ent_w |=> current_privilege_level_o == 2'h0)
    else $error("entry privilege");
  ret_priv_a: assert property (ret_w |=> current_privilege_level_o == 2'h3)
    else $error("return privilege");
  flat_load_a: assert property (ent_w || ret_w |=> flat_seg_load_o)
    else $error("no segment load");
  flag_clr_a: assert property (ent_w && long_mode_i |=> (flag_word_o & ~$past(flag_word_i)) == 0)
    else $error("flag set on entry");
  legacy_ud_a: assert property (leg_w |=> undefined_opcode_fault_o)
    else $error("no undefined opcode");
  swap_we_a: assert property (op_valid_i && op_i == fsc_pkg::FSC_OP_XCHG && long_mode_i
    |=> aux_base_we_o) else $error("no base exchange");
  no_fault_a: assert property (!msr_wr_i |=> !protection_fault_o) else $error("stray fault");
  // Main scenarios
  cover property (ent_w && long_mode_i);
  cover property (ret_w && ret_to_64_i);
  cover property (protection_fault_o);
endmodule : fsc_core_mon

bind fsc_core fsc_core_mon u_mon (.*);

// ---- tb_fast_fast_system_entry_msr_logic.sv ----
/*
  Self-checking bench for fsc_core: registers, entry, return, faults, exchange.
  Assumes the package constants and a one-cycle answer to every request.
*/
`timescale 1ns/1ns
module tb_fast_fast_system_entry_msr_logic;
  logic sys_clk_i, nrst_i, msr_wr_i, msr_rd_i, msr_ack_o, protection_fault_o;
  logic op_valid_i, long_mode_i, caller_64_i, ret_to_64_i, res_valid_o, flt;
  logic undefined_opcode_fault_o, flat_seg_load_o, aux_base_we_o;
  logic [31:0] msr_addr_i;
  logic [63:0] msr_wdata_i, msr_rdata_o, flag_word_i, aux_base_i, target_ip_o;
  logic [63:0] stack_ptr_o, flag_word_o, aux_base_o;
  logic [15:0] code_sel_o, stack_sel_o;
  logic [1:0]  current_privilege_level_o;
  fsc_pkg::fsc_op_t op_i;
  int n_errors = 0;
  int n_checks = 0;
  fsc_core DUT (.sys_clk_i, .nrst_i, .msr_wr_i, .msr_rd_i, .msr_addr_i, .msr_wdata_i,
    .msr_rdata_o, .msr_ack_o, .protection_fault_o, .op_valid_i, .op_i, .long_mode_i,
    .caller_64_i, .ret_to_64_i, .flag_word_i, .aux_base_i, .res_valid_o,
    .undefined_opcode_fault_o, .code_sel_o, .stack_sel_o, .current_privilege_level_o,
    .flat_seg_load_o, .target_ip_o, .stack_ptr_o, .flag_word_o, .aux_base_we_o, .aux_base_o);
  // ==========================================================
  // Shared tasks
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  // Register access held over one taking edge
  task acc(input logic w, input logic [31:0] a, input logic [63:0] d);
    @(posedge sys_clk_i) #1;
    {msr_wr_i, msr_rd_i} = {w, !w};
    msr_addr_i = a;
    msr_wdata_i = d;
    @(posedge sys_clk_i) #1;
    {msr_wr_i, msr_rd_i} = 2'h0;
    flt = protection_fault_o;
  endtask : acc
  task rd(input logic [31:0] a, input logic [63:0] e);
    acc(0, a, 0);
    chk("read data", e, msr_rdata_o);
  endtask : rd
  task op(input fsc_pkg::fsc_op_t c, input logic lm, input logic c64, input logic r64);
    @(posedge sys_clk_i) #1;
    {op_valid_i, op_i, long_mode_i, caller_64_i, ret_to_64_i} = {1'b1, c, lm, c64, r64};
    @(posedge sys_clk_i) #1;
    op_valid_i = 0;
  endtask : op
  // ==========================================================
  // Scenarios
  task t_regs;
    logic [31:0] ad [8] = '{32'h174, 32'h175, 32'h176, 32'hC000_0102, fsc_pkg::ADDR_TARGET,
                            fsc_pkg::ADDR_LPTR, fsc_pkg::ADDR_CPTR, fsc_pkg::ADDR_FMASK};
    rd(fsc_pkg::ADDR_TARGET, 0);
    foreach (ad[i])
    begin
      acc(1, ad[i], 64'hFFFF_8765_4321_0000 + i);
      rd(ad[i], 64'hFFFF_8765_4321_0000 + i);
    end
    rd(32'hC000_0090, 0);
  endtask : t_regs
  task t_entry;
    acc(1, fsc_pkg::ADDR_TARGET, 64'h0023_FFF8_1234_5678);
    acc(1, fsc_pkg::ADDR_FMASK, 64'h700);
    acc(1, fsc_pkg::ADDR_LPTR, 64'h7FFF_0000_1000);
    acc(1, fsc_pkg::ADDR_CPTR, 64'hFFFF_8000_0000_2000);
    flag_word_i = 64'hF02;
    op(fsc_pkg::FSC_OP_ENTRY, 0, 0, 0);
    chk("entry cs", 16'hFFF8, code_sel_o);
    chk("entry ss", 0, stack_sel_o);
    chk("entry ip", 64'h1234_5678, target_ip_o);
    op(fsc_pkg::FSC_OP_ENTRY, 1, 1, 0);
    chk("long ip", 64'h7FFF_0000_1000, target_ip_o);
    chk("flags", 64'h802, flag_word_o);
    op(fsc_pkg::FSC_OP_ENTRY, 1, 0, 0);
    chk("compat ip", 64'hFFFF_8000_0000_2000, target_ip_o);
    op(fsc_pkg::FSC_OP_RETURN, 1, 0, 0);
    chk("ret32 cs", 16'h23, code_sel_o);
    chk("ret ss", 16'h2B, stack_sel_o);
    op(fsc_pkg::FSC_OP_RETURN, 1, 0, 1);
    chk("ret64 cs", 16'h33, code_sel_o);
    acc(1, fsc_pkg::ADDR_LPTR, 64'h8000_0000_0000);
    chk("fault", 1, flt);
    rd(fsc_pkg::ADDR_LPTR, 64'h7FFF_0000_1000);
  endtask : t_entry
  task t_legacy;
    acc(1, 32'h174, 64'h10);
    op(fsc_pkg::FSC_OP_LENTRY, 0, 0, 0);
    chk("legacy cs", 16'h10, code_sel_o);
    chk("legacy ss", 16'h18, stack_sel_o);
    chk("legacy ip", 64'hFFFF_8765_4321_0002, target_ip_o);
    chk("legacy sp", 64'hFFFF_8765_4321_0001, stack_ptr_o);
    chk("legacy ud", 0, undefined_opcode_fault_o);
    op(fsc_pkg::FSC_OP_LENTRY, 1, 0, 0);
    chk("entry ud", 1, undefined_opcode_fault_o);
    op(fsc_pkg::FSC_OP_LEXIT, 1, 0, 0);
    chk("exit ud", 1, undefined_opcode_fault_o);
  endtask : t_legacy
  task t_xchg;
    acc(1, 32'hC000_0102, 64'hFFFF_8000_AAAA_0000);
    aux_base_i = 64'h5555_0000;
    op(fsc_pkg::FSC_OP_XCHG, 1, 0, 0);
    chk("aux we", 1, aux_base_we_o);
    chk("aux base", 64'hFFFF_8000_AAAA_0000, aux_base_o);
    rd(32'hC000_0102, 64'h5555_0000);
  endtask : t_xchg
  // Clock
  initial
  begin
    sys_clk_i = 0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Watchdog
  initial
  begin
    #20000;
    n_errors++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    {nrst_i, msr_wr_i, msr_rd_i, op_valid_i, long_mode_i, caller_64_i, ret_to_64_i} = 7'h0;
    {msr_addr_i, msr_wdata_i, flag_word_i, aux_base_i} = 0;
    op_i = fsc_pkg::FSC_OP_NONE;
    repeat (16) @(posedge sys_clk_i);
    #1 nrst_i = 1;
    t_regs();
    t_entry();
    t_legacy();
    t_xchg();
    end_of_test();
  end
endmodule : tb_fast_fast_system_entry_msr_logic
